// ---- hw/reset_and_clock_control.sv ----
// Reset sequencer and oscillator clock configuration, top level
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_and_clock_control #(
  parameter int POR_EXIT_CYCLES = rcc_pkg::POR_EXIT_CYC,
  parameter int RX_EXIT_CYCLES = rcc_pkg::RX_EXIT_CYC,
  parameter int SW_EXIT_CYCLES = rcc_pkg::SW_EXIT_CYC,
  parameter int CHECK_CYCLES = rcc_pkg::CHECK_CYC,
  parameter int RX_LOW_CYCLES = rcc_pkg::RX_LOW_CYC,
  parameter int RX_RAM_CYCLES = rcc_pkg::RX_RAM_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Pins
  input wire logic coreSupplyOk,
  input wire logic rxPin,
  // RAM self-check
  input wire logic ramCheckFail,
  output logic ramCheckRun,
  output logic ramAccessEnable,
  // Reset and interface enables
  output logic chipReset_n,
  output logic uartEnable,
  // Oscillator and clock selection
  output logic fastOscEnable,
  output logic slowOscEnable,
  output logic [1:0] converterRateSelect,
  output logic meterClockSelect,
  output logic [4:0] fastOscTrim,
  output logic fastOscBoost
);
  import rcc_pkg::*;

  // ****************
  // Inputs
  // ****************
  reg_bus_if bus ();
  logic [1:0] supSync_ff, nxt_supSync;
  logic supplyOk, rxLowLong, rxHigh, keyHit;

  ahb_reg_port u_port (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .bus(bus.port)
  );

  rx_reset_detect #(.LOW_CYC(RX_LOW_CYCLES)) u_rx (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .rxPin(rxPin),
    .rxLowLong(rxLowLong),
    .rxHigh(rxHigh)
  );

  assign nxt_supSync = {supSync_ff[0], coreSupplyOk};
  assign supplyOk = supSync_ff[1];

  // ****************
  // Sequencer
  // ****************
  seq_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [2:0] cause_ff, nxt_cause;
  logic run_ff, ram_ff, check_ff;
  logic nxt_run;

  function automatic logic is_running(input seq_state_t s);
    return s == ST_CHECK || s == ST_READY || s == ST_FAULT;
  endfunction

  // A hold state owns the chip until its source lets go
  assign keyHit = bus.wrStrobe && bus.index == SOFT_KEY_IDX &&
    bus.wdata == SOFT_KEY && state_ff != ST_POR_HOLD &&
    state_ff != ST_RX_HOLD;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_cause = cause_ff;
    if (!supplyOk) begin
      nxt_state = ST_POR_HOLD;
      nxt_cause = CAUSE_POR;
    end else if (rxLowLong && state_ff != ST_RX_HOLD) begin
      nxt_state = ST_RX_HOLD;
      nxt_cause = CAUSE_RX;
    end else if (keyHit) begin
      nxt_state = ST_EXIT;
      nxt_cause = CAUSE_SW;
      nxt_cnt = CNT_W'(SW_EXIT_CYCLES - 1);
    end else begin
      case (state_ff)
        ST_POR_HOLD: begin
          nxt_state = ST_EXIT;
          nxt_cnt = CNT_W'(POR_EXIT_CYCLES - 1);
        end
        ST_RX_HOLD: begin
          if (rxHigh) begin
            nxt_state = ST_EXIT;
            nxt_cnt = CNT_W'(RX_EXIT_CYCLES - 1);
          end
        end
        ST_EXIT: begin
          if (cnt_ff == '0) begin
            nxt_state = ST_CHECK;
            // After a line reset the RAM wait runs from line release
            if (cause_ff == CAUSE_RX) begin
              nxt_cnt = CNT_W'(RX_RAM_CYCLES - RX_EXIT_CYCLES - 1);
            end else begin
              nxt_cnt = CNT_W'(CHECK_CYCLES - 1);
            end
          end else begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
        ST_CHECK: begin
          if (ramCheckFail) begin
            nxt_state = ST_FAULT;
          end else if (cnt_ff == '0) begin
            nxt_state = ST_READY;
          end else begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
        ST_READY: begin
        end
        ST_FAULT: begin
        end
        default: begin
          nxt_state = ST_POR_HOLD;
        end
      endcase
    end
    nxt_run = is_running(nxt_state);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      supSync_ff <= 2'h0;
      state_ff <= ST_POR_HOLD;
      cnt_ff <= '0;
      cause_ff <= CAUSE_POR;
      run_ff <= 1'b0;
      ram_ff <= 1'b0;
      check_ff <= 1'b0;
    end else if (clkEnable) begin
      supSync_ff <= nxt_supSync;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cause_ff <= nxt_cause;
      run_ff <= nxt_run;
      ram_ff <= nxt_state == ST_READY;
      check_ff <= nxt_state == ST_CHECK;
    end
  end

  // ****************
  // Registers
  // ****************
  logic [31:0] system_control_ff, nxt_system_control, key_ff, nxt_key;
  logic oscEn_ff, nxt_oscEn;

  always_comb begin
    nxt_system_control = system_control_ff;
    nxt_key = key_ff;
    nxt_oscEn = oscEn_ff;
    if (!nxt_run) begin
      nxt_system_control = SYS_CONTROL_RESET;
      nxt_key = SOFT_KEY_RESET;
      nxt_oscEn = OSC_EN_RESET;
    end else if (bus.wrStrobe) begin
      case (bus.index)
        SYS_CONTROL_IDX: nxt_system_control = bus.wdata & SYS_CONTROL_MASK;
        SOFT_KEY_IDX: nxt_key = bus.wdata;
        OSC_CONTROL_IDX: nxt_oscEn = bus.wdata[OSC_EN_BIT];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      system_control_ff <= SYS_CONTROL_RESET;
      key_ff <= SOFT_KEY_RESET;
      oscEn_ff <= OSC_EN_RESET;
    end else if (clkEnable) begin
      system_control_ff <= nxt_system_control;
      key_ff <= nxt_key;
      oscEn_ff <= nxt_oscEn;
    end
  end

  always_comb begin
    bus.rdata = 32'h0000_0000;
    case (bus.index)
      SYS_STATUS_IDX: bus.rdata[CAUSE_LSB+:3] = cause_ff;
      SYS_CONTROL_IDX: bus.rdata = system_control_ff;
      SOFT_KEY_IDX: bus.rdata = key_ff;
      OSC_CONTROL_IDX: bus.rdata[OSC_EN_BIT] = oscEn_ff;
      SEQ_STATUS_IDX: bus.rdata[2:0] =
        {state_ff == ST_FAULT, !run_ff, ram_ff};
      default: bus.rdata = 32'h0000_0000;
    endcase
  end

  // ****************
  // Outputs
  // ****************
  assign chipReset_n = run_ff;
  assign uartEnable = run_ff;
  assign ramAccessEnable = ram_ff;
  assign ramCheckRun = check_ff;
  assign fastOscEnable = oscEn_ff;
  // No register bit reaches this; the slow clock cannot be stopped
  assign slowOscEnable = 1'b1;
  assign converterRateSelect = system_control_ff[RATE_LSB+:2];
  assign meterClockSelect = system_control_ff[METER_CLK_BIT];
  assign fastOscTrim = system_control_ff[TRIM_LSB+:5];
  assign fastOscBoost = system_control_ff[BOOST_BIT];

  // ****************
  // Checks
  // ****************
  logic [CNT_W-1:0] exitLen_ff;
  logic [CNT_W-1:0] exitWant;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      exitLen_ff <= '0;
    end else if (clkEnable) begin
      exitLen_ff <= (state_ff == ST_EXIT && nxt_state == ST_EXIT &&
        !keyHit) ? exitLen_ff + 1'b1 : '0;
    end
  end

  assign exitWant = (cause_ff == CAUSE_RX) ?
    CNT_W'(RX_EXIT_CYCLES - 1) : (cause_ff == CAUSE_SW) ?
    CNT_W'(SW_EXIT_CYCLES - 1) : CNT_W'(POR_EXIT_CYCLES - 1);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_ctrl_write;
    clkEnable && bus.wrStrobe && bus.index == SYS_CONTROL_IDX && nxt_run;
  endsequence

  property p_por_hold;
    !supplyOk && clkEnable |=> state_ff == ST_POR_HOLD ##1 !chipReset_n;
  endproperty
  a_por_hold: assert property (p_por_hold)
    else $error("supply low did not hold reset");

  property p_por_cause;
    !supplyOk && clkEnable |=> cause_ff == CAUSE_POR;
  endproperty
  a_por_cause: assert property (p_por_cause)
    else $error("power-on cause code wrong");

  property p_rx_cause;
    supplyOk && rxLowLong && state_ff != ST_RX_HOLD && clkEnable
      |=> cause_ff == CAUSE_RX && state_ff == ST_RX_HOLD;
  endproperty
  a_rx_cause: assert property (p_rx_cause)
    else $error("line reset cause or state wrong");

  property p_sw_cause;
    supplyOk && !rxLowLong && keyHit && clkEnable
      |=> cause_ff == CAUSE_SW && !chipReset_n;
  endproperty
  a_sw_cause: assert property (p_sw_cause)
    else $error("software reset cause wrong");

  property p_ram_blocked;
    !chipReset_n |-> !ramAccessEnable;
  endproperty
  a_ram_blocked: assert property (p_ram_blocked)
    else $error("RAM open during reset");

  property p_uart;
    uartEnable == is_running(state_ff);
  endproperty
  a_uart: assert property (p_uart)
    else $error("UART enable not tied to reset release");

  property p_exit_len;
    state_ff == ST_EXIT && nxt_state == ST_CHECK && clkEnable
      |-> exitLen_ff == exitWant;
  endproperty
  a_exit_len: assert property (p_exit_len)
    else $error("reset exit delay wrong");

  property p_osc_on;
    !chipReset_n |-> fastOscEnable && slowOscEnable;
  endproperty
  a_osc_on: assert property (p_osc_on)
    else $error("oscillator off during reset");

  property p_ctrl_write;
    s_ctrl_write |=> converterRateSelect == $past(bus.wdata[21:20]) &&
      meterClockSelect == $past(bus.wdata[19]) &&
      fastOscTrim == $past(bus.wdata[11:7]) &&
      fastOscBoost == $past(bus.wdata[6]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control fields not taken from write");

  property p_ctrl_default;
    !chipReset_n |-> converterRateSelect == 2'h0 && !meterClockSelect &&
      fastOscTrim == 5'h00 && !fastOscBoost;
  endproperty
  a_ctrl_default: assert property (p_ctrl_default)
    else $error("control not at default in reset");

  property p_cause_legal;
    cause_ff == CAUSE_POR || cause_ff == CAUSE_RX || cause_ff == CAUSE_SW;
  endproperty
  a_cause_legal: assert property (p_cause_legal)
    else $error("illegal cause code");

  property p_ram_after_check;
    $rose(ramAccessEnable) |-> $past(state_ff) == ST_CHECK &&
      $past(cnt_ff) == '0 && !$past(ramCheckFail);
  endproperty
  a_ram_after_check: assert property (p_ram_after_check)
    else $error("RAM opened without finished check");
endmodule // reset_and_clock_control
`default_nettype wire

// ---- hw/rcc_pkg.sv ----
// Shared constants and types for reset and clock control
package rcc_pkg;
  // ****************
  // Timing
  // ****************
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_EXIT_NS = 500_000;
  localparam int RX_EXIT_NS = 900_000;
  localparam int SW_EXIT_NS = 650_000;
  localparam int CHECK_NS = 1_250_000;
  localparam int RX_LOW_NS = 70_000_000;
  localparam int RX_RAM_NS = 30_900_000;
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int POR_EXIT_CYC = ceil_cyc(POR_EXIT_NS);
  localparam int RX_EXIT_CYC = ceil_cyc(RX_EXIT_NS);
  localparam int SW_EXIT_CYC = ceil_cyc(SW_EXIT_NS);
  localparam int CHECK_CYC = ceil_cyc(CHECK_NS);
  localparam int RX_LOW_CYC = RX_LOW_NS / CLK_PERIOD_NS;
  localparam int RX_RAM_CYC = ceil_cyc(RX_RAM_NS);
  localparam int CNT_W = 20;
  // ****************
  // Register map, word indices
  // ****************
  localparam int IDX_W = 9;
  localparam logic [8:0] SYS_STATUS_IDX = 9'h0ca;
  localparam logic [8:0] SYS_CONTROL_IDX = 9'h180;
  localparam logic [8:0] SOFT_KEY_IDX = 9'h1bf;
  localparam logic [8:0] OSC_CONTROL_IDX = 9'h1c0;
  localparam logic [8:0] SEQ_STATUS_IDX = 9'h1c1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int CAUSE_LSB = 3;
  localparam int RATE_LSB = 20;
  localparam int METER_CLK_BIT = 19;
  localparam int TRIM_LSB = 7;
  localparam int BOOST_BIT = 6;
  localparam int OSC_EN_BIT = 0;
  localparam logic [31:0] SYS_CONTROL_MASK = 32'h0038_0fc0;
  localparam logic [31:0] SYS_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] SOFT_KEY_RESET = 32'h0000_0000;
  localparam logic OSC_EN_RESET = 1'b1;
  localparam logic [31:0] SOFT_KEY = 32'h4572_beaf;
  localparam logic [2:0] CAUSE_POR = 3'h1;
  localparam logic [2:0] CAUSE_RX = 3'h3;
  localparam logic [2:0] CAUSE_SW = 3'h4;
  typedef enum logic [2:0] {
    ST_POR_HOLD, ST_RX_HOLD, ST_EXIT, ST_CHECK, ST_READY, ST_FAULT
  } seq_state_t;
  function automatic logic is_mapped(input logic [8:0] idx);
    return idx == SYS_STATUS_IDX || idx == SYS_CONTROL_IDX ||
      idx == SOFT_KEY_IDX || idx == OSC_CONTROL_IDX ||
      idx == SEQ_STATUS_IDX;
  endfunction
endpackage

// ---- hw/reg_bus_if.sv ----
// Internal register access path between bus port and register file
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
  logic wrStrobe;
  logic [rcc_pkg::IDX_W-1:0] index;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport port (output wrStrobe, output index, output wdata,
    input rdata);
  modport regs (input wrStrobe, input index, input wdata,
    output rdata);
endinterface
`default_nettype wire

// ---- hw/ahb_reg_port.sv ----
// AHB-Lite slave front end with one wait state per transfer
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Register side
  reg_bus_if.port bus
);
  import rcc_pkg::*;
  logic pend_ff, write_ff, hit_ff, ready_ff;
  logic nxt_pend, nxt_write, nxt_hit, nxt_ready;
  logic [IDX_W-1:0] idx_ff, nxt_idx;
  logic [31:0] rdata_ff, nxt_rdata;
  logic accept;

  assign accept = hsel && htrans[1] && hready;

  always_comb begin
    nxt_pend = pend_ff;
    nxt_write = write_ff;
    nxt_hit = hit_ff;
    nxt_idx = idx_ff;
    nxt_ready = ready_ff;
    nxt_rdata = rdata_ff;
    if (pend_ff) begin
      // Read sampled after any write of the previous transfer landed
      nxt_pend = 1'b0;
      nxt_ready = 1'b1;
      nxt_rdata = (!write_ff && hit_ff) ? bus.rdata : 32'h0000_0000;
    end else if (accept) begin
      nxt_pend = 1'b1;
      nxt_ready = 1'b0;
      nxt_write = hwrite;
      nxt_idx = haddr[IDX_W+1:2];
      nxt_hit = haddr[31:IDX_W+2] == '0 && haddr[1:0] == 2'h0 &&
        hsize == HSIZE_WORD && is_mapped(haddr[IDX_W+1:2]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pend_ff <= 1'b0;
      write_ff <= 1'b0;
      hit_ff <= 1'b0;
      idx_ff <= '0;
      ready_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else if (clkEnable) begin
      pend_ff <= nxt_pend;
      write_ff <= nxt_write;
      hit_ff <= nxt_hit;
      idx_ff <= nxt_idx;
      ready_ff <= nxt_ready;
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus.wrStrobe = pend_ff && write_ff && hit_ff;
  assign bus.index = idx_ff;
  assign bus.wdata = hwdata;
  assign hreadyout = ready_ff;
  assign hrdata = rdata_ff;
  assign hresp = 1'b0;
endmodule // ahb_reg_port
`default_nettype wire

// ---- hw/rx_reset_detect.sv ----
// Receive-line long-low detector with input synchroniser
`timescale 1ns/1ps
`default_nettype none
module rx_reset_detect #(
  parameter int LOW_CYC = rcc_pkg::RX_LOW_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  // Pin and result
  input wire logic rxPin,
  output logic rxLowLong,
  output logic rxHigh
);
  import rcc_pkg::*;
  logic [1:0] sync_ff, nxt_sync;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic low_ff, nxt_low;

  always_comb begin
    nxt_sync = {sync_ff[0], rxPin};
    nxt_cnt = cnt_ff;
    if (sync_ff[1]) begin
      nxt_cnt = '0;
    end else if (cnt_ff != CNT_W'(LOW_CYC)) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    // Saturates, so a line held low for minutes still means one reset
    nxt_low = nxt_cnt == CNT_W'(LOW_CYC);
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync_ff <= 2'h3;
      cnt_ff <= '0;
      low_ff <= 1'b0;
    end else if (clkEnable) begin
      sync_ff <= nxt_sync;
      cnt_ff <= nxt_cnt;
      low_ff <= nxt_low;
    end
  end

  assign rxLowLong = low_ff;
  assign rxHigh = sync_ff[1];
endmodule // rx_reset_detect
`default_nettype wire

// ---- bench/rx_host_model.sv ----
// Host-side model that drives the device's UART receive line
`timescale 1ns/1ps
`default_nettype none
module rx_host_model (
  // Clock
  input wire logic ref_clk,
  // Receive line toward the device
  output logic rxPin
);
  // ****************
  // Line driver
  // ****************
  // Idle level high, as between UART frames
  initial rxPin = 1'b1;
  // Long low level; length chosen by the caller to cross or miss the limit
  task automatic hold_low(input int cycles);
    @(posedge ref_clk);
    rxPin <= 1'b0;
    repeat (cycles) @(posedge ref_clk);
    rxPin <= 1'b1;
  endtask
endmodule // rx_host_model
`default_nettype wire

// ---- bench/reset_and_clock_control_tb.sv ----
// Self-checking bench for reset sequencing and clock configuration
`timescale 1ns/1ps
`default_nettype none
module reset_and_clock_control_tb;
  import rcc_pkg::*;
  // ****************
  // Setup
  // ****************
  // Shortened counts keep the run small
  localparam int POR_X = 5;
  localparam int RX_X = 9;
  localparam int SW_X = 7;
  localparam int CHK = 12;
  localparam int RX_LOW = 40;
  localparam int RX_RAM = 30;
  localparam int LIMIT = 3000;
  logic ref_clk, reset_n, hsel, hwrite, hreadyout, hresp, rxPin;
  logic coreSupplyOk, ramCheckFail, ramCheckRun, ramAccessEnable;
  logic chipReset_n, uartEnable, fastOscEnable, slowOscEnable;
  logic meterClockSelect, fastOscBoost;
  logic [1:0] htrans, converterRateSelect;
  logic [2:0] hsize;
  logic [4:0] fastOscTrim;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [4:0] trims [4] = '{5'h01, 5'h0f, 5'h10, 5'h1f};
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int k;
  int t;
  reset_and_clock_control #(.POR_EXIT_CYCLES(POR_X), .RX_EXIT_CYCLES(RX_X),
    .SW_EXIT_CYCLES(SW_X), .CHECK_CYCLES(CHK), .RX_LOW_CYCLES(RX_LOW),
    .RX_RAM_CYCLES(RX_RAM)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
    .clkEnable(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .coreSupplyOk(coreSupplyOk), .rxPin(rxPin),
    .ramCheckFail(ramCheckFail), .ramCheckRun(ramCheckRun),
    .ramAccessEnable(ramAccessEnable), .chipReset_n(chipReset_n),
    .uartEnable(uartEnable), .fastOscEnable(fastOscEnable),
    .slowOscEnable(slowOscEnable), .converterRateSelect(converterRateSelect),
    .meterClockSelect(meterClockSelect), .fastOscTrim(fastOscTrim),
    .fastOscBoost(fastOscBoost));
  rx_host_model host (.ref_clk(ref_clk), .rxPin(rxPin));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc >= LIMIT) begin
      miscompares++;
      end_sim;
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // Single word transfer; waits on hready, only the hang guard ends it
  task automatic bus(input logic wr, input logic [8:0] idx,
      input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {21'h0, idx, 2'b00};
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do begin
      @(posedge ref_clk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge ref_clk);
    end while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [8:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return chipReset_n;
      1: return ramAccessEnable;
      default: return ramCheckRun;
    endcase
  endfunction
  // Counts settled clock edges until the chosen output reaches a level
  task automatic wait_lvl(input int sel, input logic lvl);
    #1;
    k = 0;
    while (pick(sel) !== lvl && k < 500) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
  endtask
  task automatic end_sim;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    coreSupplyOk = 1'b1;
    ramCheckFail = 1'b0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    wait_lvl(0, 1'b1);
    chk(ramAccessEnable, 1'b0);
    wait_lvl(1, 1'b1);
    chk_rng(k, CHK, CHK);
    rd_chk(SYS_STATUS_IDX, {26'h0, CAUSE_POR, 3'h0});
    rd_chk(OSC_CONTROL_IDX, 32'h1);
    $display("test power_on done");
    // Supply dip; the sync stages add a few edges either way
    @(posedge ref_clk);
    coreSupplyOk <= 1'b0;
    wait_lvl(0, 1'b0);
    chk_rng(k, 2, 5);
    chk(ramAccessEnable, 1'b0);
    chk(uartEnable, 1'b0);
    repeat (20) @(posedge ref_clk);
    coreSupplyOk <= 1'b1;
    wait_lvl(0, 1'b1);
    chk_rng(k, POR_X, POR_X + 4);
    chk(uartEnable, 1'b1);
    wait_lvl(1, 1'b1);
    chk_rng(k, CHK, CHK);
    rd_chk(SYS_STATUS_IDX, {26'h0, CAUSE_POR, 3'h0});
    $display("test supply done");
    // Every rate code, each a quarter or eighth of its meter clock
    for (int i = 0; i < 4; i++) begin
      v = {10'h0, 2'(i), i[1], 7'h0, trims[i], ~i[0], 6'h0};
      bus(1'b1, SYS_CONTROL_IDX, v | 32'hffc0_f03f);
      rd_chk(SYS_CONTROL_IDX, v);
      chk({converterRateSelect, meterClockSelect, fastOscTrim,
        fastOscBoost}, {2'(i), i[1], trims[i], ~i[0]});
    end
    bus(1'b1, OSC_CONTROL_IDX, 32'h0);
    chk(fastOscEnable, 1'b0);
    chk(slowOscEnable, 1'b1);
    bus(1'b1, 9'h100, 32'hffff_ffff);
    rd_chk(9'h100, 32'h0);
    bus(1'b1, SYS_STATUS_IDX, 32'hffff_ffff);
    rd_chk(SYS_STATUS_IDX, {26'h0, CAUSE_POR, 3'h0});
    bus(1'b1, SOFT_KEY_IDX, SOFT_KEY ^ 32'h1);
    chk(chipReset_n, 1'b1);
    rd_chk(SOFT_KEY_IDX, SOFT_KEY ^ 32'h1);
    $display("test registers done");
    // Exact key starts the software reset at the write edge
    bus(1'b1, SOFT_KEY_IDX, SOFT_KEY);
    wait_lvl(0, 1'b0);
    chk_rng(k, 0, 0);
    chk(ramAccessEnable, 1'b0);
    wait_lvl(0, 1'b1);
    // Reset began at the write edge, one edge before the task returned
    chk_rng(k + 1, SW_X, SW_X);
    chk(ramCheckRun, 1'b1);
    chk(uartEnable, 1'b1);
    wait_lvl(1, 1'b1);
    chk_rng(k, CHK, CHK);
    rd_chk(SYS_STATUS_IDX, {26'h0, CAUSE_SW, 3'h0});
    rd_chk(SYS_CONTROL_IDX, SYS_CONTROL_RESET);
    rd_chk(SOFT_KEY_IDX, SOFT_KEY_RESET);
    chk(fastOscEnable, 1'b1);
    $display("test soft_reset done");
    // Self-check error keeps RAM closed
    bus(1'b1, SOFT_KEY_IDX, SOFT_KEY);
    wait_lvl(2, 1'b1);
    @(posedge ref_clk);
    ramCheckFail <= 1'b1;
    repeat (CHK + 4) @(posedge ref_clk);
    chk(ramAccessEnable, 1'b0);
    rd_chk(SEQ_STATUS_IDX, 32'h4);
    ramCheckFail <= 1'b0;
    $display("test check_fail done");
    // Low level too short, then long enough
    host.hold_low(RX_LOW - 8);
    repeat (RX_LOW) @(posedge ref_clk);
    chk(chipReset_n, 1'b1);
    host.hold_low(RX_LOW + 4);
    chk(chipReset_n, 1'b0);
    wait_lvl(0, 1'b1);
    t = k;
    chk_rng(k, RX_X, RX_X + 4);
    // Host keeps off the RAM until it opens
    wait_lvl(1, 1'b1);
    chk_rng(t + k, RX_RAM, RX_RAM + 4);
    rd_chk(SYS_STATUS_IDX, {26'h0, CAUSE_RX, 3'h0});
    rd_chk(SYS_CONTROL_IDX, SYS_CONTROL_RESET);
    $display("test rx_reset done");
    end_sim;
  end
endmodule // reset_and_clock_control_tb
`default_nettype wire
